// file: src/iefs_stage.sv
// Trip-decision logic of the intermittent transient earth fault stage
//
// Behaviour
// RULE1: trip needs delay, peaks and window together
// RULE2: delay starts at first peak; peaks counted
// RULE3: peaks met, delay expires: trip then
// RULE4: delay expired, peaks short: wait window
// RULE5: late last peak inside window trips instantly
// RULE6: window expires before delay: release, no trip
// RULE7: new peak in window resumes delay count
// RULE8: reset delay holds start after release
// RULE9: peak count setting 1 to 20
// RULE10: operate delay 0.02 to 300 s
// RULE11: intermittent time 0.01 to 300 s
// RULE12: reject delay below peaks times 10 ms
// RULE13: peak must exceed fundamental peak
// RULE14: start output usable as blocking input
// RULE15: block input stops start and trip
// RULE16: status and clearable start/trip counters
// RULE17: four setting groups, manual or external
// RULE18: force flag clears after five minutes
// RULE19: direction mode selects counted peak direction
// RULE20: record latest eight faults with details
// RULE21: elapsed delay as percent, trip 100
// RULE22: fixed pickup level detects a peak
// RULE23: operating peak needs voltage and direction
// RULE24: timers count 10 ms ticks
`timescale 1ns/1ps
module iefs_stage
	import iefs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	// Register port
	input  wire logic [ADDR_W-1:0]  addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [31:0]        rdata_o,
	// Sample front end
	input  wire logic               smp_vld_i,
	input  wire logic signed [15:0] io_smp_i,
	input  wire logic [15:0]        io_fund_pk_i,
	input  wire logic [15:0]        uo_i,
	input  wire logic               dir_fwd_i,
	input  wire logic [31:0]        rtc_i,
	// External control
	input  wire logic               block_i,
	input  wire logic [1:0]         grp_ext_i,
	// Stage outputs
	output logic                    start_o,
	output logic                    trip_o
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	iefs_set_t   grp_set_r [4];
	iefs_rec_t   rec_r [8];
	iefs_state_t st_r, st_nxt;
	logic [23:0] tick_cnt_r;
	logic        tick;
	logic [15:0] op_cnt_r, int_cnt_r, rst_cnt_r, scnt_r, tcnt_r, frc_cnt_r;
	logic [4:0]  pk_cnt_r;
	logic [15:0] max_io_r, max_uo_r;
	logic [7:0]  fwd_r, rev_r;
	logic [31:0] stamp_r;
	logic [2:0]  wp_r;
	logic        trip_r, err_r, force_r, gsrc_r, fstart_r, ftrip_r, blk_r;
	logic [1:0]  gman_r;
	logic [31:0] rdata_nxt;

	// ------------------------------------------------------------
	// Group select and peak qualification
	// ------------------------------------------------------------
	wire logic [1:0]  act_grp = gsrc_r ? grp_ext_i : gman_r;
	wire iefs_set_t   as      = grp_set_r[act_grp];
	wire logic [15:0] io_abs  = io_smp_i[15] ? 16'(-io_smp_i) : 16'(io_smp_i);
	// RULE22 fixed pickup, RULE13 above fundamental peak
	wire logic peak_det = smp_vld_i && (io_abs > IO_PICKUP) && (io_abs > io_fund_pk_i);
	wire logic uo_ok    = uo_i > as.uo_pk;
	// RULE23 voltage and direction gate, RULE19 direction mode
	wire logic qual     = peak_det && uo_ok && (dir_fwd_i ^ as.dir_rev);
	wire logic op_done  = op_cnt_r >= as.tdly;
	wire logic peak_ok  = pk_cnt_r >= as.peaks;
	wire logic int_done = int_cnt_r >= as.intrmt;
	wire logic rst_done = rst_cnt_r >= as.rst;
	wire logic in_ep    = st_r != ST_IDLE;
	wire logic ep_end   = (st_r == ST_HOLD) && (st_nxt == ST_IDLE);

	// ------------------------------------------------------------
	// Tick base
	// ------------------------------------------------------------
	// RULE24 10 ms tick
	assign tick = tick_cnt_r == 24'(TICK_CYCLES - 1);
	always_ff @(posedge clk_i) begin
		if (srst_i || tick) tick_cnt_r <= '0;
		else tick_cnt_r <= tick_cnt_r + 24'h1;
	end

	// ------------------------------------------------------------
	// Episode state machine
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				// RULE2 first peak starts episode
				if (qual) st_nxt = ST_RUN;
			end
			ST_RUN: begin
				// RULE1 RULE3 RULE5 all criteria together
				if (op_done && peak_ok) st_nxt = ST_TRIP;
				// RULE4 RULE6 window ran out
				else if (int_done) st_nxt = ST_HOLD;
			end
			ST_TRIP: begin
				if (int_done) st_nxt = ST_HOLD;
			end
			ST_HOLD: begin
				// RULE7 peak resumes the episode
				if (qual) st_nxt = ST_RUN;
				// RULE8 release only after reset delay
				else if (rst_done) st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
		// RULE15 blocked stage stays idle
		if (block_i) st_nxt = ST_IDLE;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r   <= ST_IDLE;
			trip_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			trip_r <= (st_nxt == ST_TRIP) || (trip_r && st_nxt != ST_IDLE);
		end
	end

	// ------------------------------------------------------------
	// Episode timers and counters
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i || st_nxt == ST_IDLE) begin
			op_cnt_r  <= '0;
			int_cnt_r <= '0;
			rst_cnt_r <= '0;
			pk_cnt_r  <= '0;
		end else begin
			// RULE2 RULE7 delay accumulates across peaks
			if (st_r == ST_RUN && tick && !op_done) op_cnt_r <= op_cnt_r + 16'h1;
			if (qual) int_cnt_r <= '0;
			else if (st_r != ST_HOLD && tick && !int_done) int_cnt_r <= int_cnt_r + 16'h1;
			if (st_r != ST_HOLD) rst_cnt_r <= '0;
			else if (tick && !rst_done) rst_cnt_r <= rst_cnt_r + 16'h1;
			if (qual && pk_cnt_r != 5'h1f) pk_cnt_r <= pk_cnt_r + 5'h1;
		end
	end

	// Fault capture for the recorder
	always_ff @(posedge clk_i) begin
		if (srst_i || (!in_ep && !qual)) begin
			max_io_r <= '0;
			max_uo_r <= '0;
			fwd_r    <= '0;
			rev_r    <= '0;
		end else if (peak_det && uo_ok) begin
			if (io_abs > max_io_r) max_io_r <= io_abs;
			if (uo_i > max_uo_r) max_uo_r <= uo_i;
			if (dir_fwd_i && fwd_r != 8'hff) fwd_r <= fwd_r + 8'h1;
			if (!dir_fwd_i && rev_r != 8'hff) rev_r <= rev_r + 8'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) stamp_r <= '0;
		else if (!in_ep && qual) stamp_r <= rtc_i;
	end

	// ------------------------------------------------------------
	// Fault recorder
	// ------------------------------------------------------------
	// RULE21 percent of operate delay, trip reads full
	wire logic [22:0] elapsed_delay_pct_q = ({7'h0, op_cnt_r} * 23'd100) / {7'h0, as.tdly};
	wire logic [7:0]  elapsed_delay_pct_w = (trip_r || elapsed_delay_pct_q >= 23'(PCT_FULL)) ? PCT_FULL : elapsed_delay_pct_q[7:0];
	wire iefs_rec_t   rec_w  = '{stamp: stamp_r, max_io: max_io_r, max_uo: max_uo_r,
		elapsed_delay_pct: elapsed_delay_pct_w, grp: act_grp, fwd: fwd_r, rev: rev_r};

	// RULE20 ring of eight latest faults
	generate
		for (genvar e = 0; e < 8; e++) begin : g_rec
			always_ff @(posedge clk_i) begin
				if (srst_i) rec_r[e] <= REC_RST;
				else if (ep_end && wp_r == 3'(e)) rec_r[e] <= rec_w;
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (srst_i) wp_r <= '0;
		else if (ep_end) wp_r <= wp_r + 3'h1;
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	wire logic       wr_ctrl = wr_i && (addr_i == A_CTRL);
	wire logic       wr_grp  = wr_i && (addr_i[9:7] == GRP_PAGE);
	wire logic [1:0] wg      = addr_i[6:5];
	wire logic [2:0] wf      = addr_i[4:2];
	wire iefs_set_t  cur     = grp_set_r[wg];
	wire logic [15:0] val    = wdata_i[15:0];
	wire logic       hi_zero = wdata_i[31:16] == 16'h0;
	// RULE10 RULE12 delay range and peak spacing
	wire logic ok_tdly  = hi_zero && val >= TDLY_MIN && val <= T_MAX
		&& val >= 16'({11'h0, cur.peaks} * PEAK_TICKS);
	// RULE9 RULE12 peak count range and spacing
	wire logic ok_peaks = wdata_i >= PEAKS_MIN && wdata_i <= PEAKS_MAX
		&& cur.tdly >= 16'({11'h0, wdata_i[4:0]} * PEAK_TICKS);
	// RULE11 intermittent time range
	wire logic ok_int   = hi_zero && val >= INT_MIN && val <= T_MAX;
	// RULE8 reset delay range
	wire logic ok_rst   = hi_zero && val >= RST_MIN && val <= T_MAX;
	wire logic f_ok     = (wf == F_TDLY) ? ok_tdly : (wf == F_PEAKS) ? ok_peaks :
		(wf == F_INT) ? ok_int : (wf == F_RST) ? ok_rst : 1'b1;
	wire logic f_known  = wf <= F_DIR;
	wire logic wr_bad   = wr_grp && f_known && !f_ok;

	// RULE17 four setting groups
	generate
		for (genvar g = 0; g < 4; g++) begin : g_grp
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					grp_set_r[g] <= SET_RST;
				end else if (wr_grp && f_ok && wg == 2'(g)) begin
					case (wf)
						F_TDLY:  grp_set_r[g].tdly    <= val;
						F_PEAKS: grp_set_r[g].peaks   <= wdata_i[4:0];
						F_INT:   grp_set_r[g].intrmt  <= val;
						F_RST:   grp_set_r[g].rst     <= val;
						F_UOPK:  grp_set_r[g].uo_pk   <= val;
						F_DIR:   grp_set_r[g].dir_rev <= wdata_i[0];
						default: grp_set_r[g] <= grp_set_r[g];
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			gsrc_r   <= 1'b0;
			gman_r   <= '0;
			fstart_r <= 1'b0;
			ftrip_r  <= 1'b0;
			err_r    <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				gsrc_r   <= wdata_i[C_GSRC];
				gman_r   <= wdata_i[C_GRP_LO +: 2];
				fstart_r <= wdata_i[C_FSTART];
				ftrip_r  <= wdata_i[C_FTRIP];
			end
			// Rejection sets win over a clear in the same cycle
			if (wr_bad) err_r <= 1'b1;
			else if (wr_ctrl && wdata_i[C_CLRE]) err_r <= 1'b0;
		end
	end

	// RULE18 force flag with timeout
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			force_r   <= 1'b0;
			frc_cnt_r <= '0;
		end else if (wr_ctrl) begin
			force_r   <= wdata_i[C_FORCE];
			frc_cnt_r <= '0;
		end else if (force_r && frc_cnt_r >= FORCE_TICKS) begin
			force_r   <= 1'b0;
		end else if (force_r && tick) begin
			frc_cnt_r <= frc_cnt_r + 16'h1;
		end
	end

	// RULE16 cumulative counters, clear keeps a same-cycle count
	wire logic s_evt = (st_r == ST_IDLE) && (st_nxt == ST_RUN);
	wire logic t_evt = (st_nxt == ST_TRIP) && !trip_r;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			scnt_r <= '0;
			tcnt_r <= '0;
		end else begin
			if (wr_ctrl && wdata_i[C_CLRS]) scnt_r <= {15'h0, s_evt};
			else if (s_evt) scnt_r <= scnt_r + 16'h1;
			if (wr_ctrl && wdata_i[C_CLRT]) tcnt_r <= {15'h0, t_evt};
			else if (t_evt) tcnt_r <= tcnt_r + 16'h1;
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	wire iefs_rec_t rr = rec_r[addr_i[7:5]];
	wire logic [31:0] ctrl_rd = {22'h0, ftrip_r, fstart_r, 4'h0, gman_r, gsrc_r, force_r};
	// RULE16 blocked, started, tripped status
	wire logic [31:0] stat_rd = {24'h0, err_r, force_r, act_grp, 1'b0, trip_r, in_ep, blk_r};
	always_comb begin
		rdata_nxt = '0;
		if (addr_i == A_CTRL) rdata_nxt = ctrl_rd;
		else if (addr_i == A_STAT) rdata_nxt = stat_rd;
		else if (addr_i == A_SCNT) rdata_nxt = {16'h0, scnt_r};
		else if (addr_i == A_TCNT) rdata_nxt = {16'h0, tcnt_r};
		else if (addr_i[9:7] == GRP_PAGE && wf == F_TDLY) rdata_nxt = {16'h0, cur.tdly};
		else if (addr_i[9:7] == GRP_PAGE && wf == F_PEAKS) rdata_nxt = {27'h0, cur.peaks};
		else if (addr_i[9:7] == GRP_PAGE && wf == F_INT) rdata_nxt = {16'h0, cur.intrmt};
		else if (addr_i[9:7] == GRP_PAGE && wf == F_RST) rdata_nxt = {16'h0, cur.rst};
		else if (addr_i[9:7] == GRP_PAGE && wf == F_UOPK) rdata_nxt = {16'h0, cur.uo_pk};
		else if (addr_i[9:7] == GRP_PAGE && wf == F_DIR) rdata_nxt = {31'h0, cur.dir_rev};
		else if (addr_i[9:8] == REC_PAGE && wf == R_STAMP) rdata_nxt = rr.stamp;
		else if (addr_i[9:8] == REC_PAGE && wf == R_MAXIO) rdata_nxt = {16'h0, rr.max_io};
		else if (addr_i[9:8] == REC_PAGE && wf == R_MAXUO) rdata_nxt = {16'h0, rr.max_uo};
		else if (addr_i[9:8] == REC_PAGE && wf == R_ELAPSED_DELAY_PCT) rdata_nxt = {24'h0, rr.elapsed_delay_pct};
		else if (addr_i[9:8] == REC_PAGE && wf == R_GRP) rdata_nxt = {30'h0, rr.grp};
		else if (addr_i[9:8] == REC_PAGE && wf == R_FWD) rdata_nxt = {24'h0, rr.fwd};
		else if (addr_i[9:8] == REC_PAGE && wf == R_REV) rdata_nxt = {24'h0, rr.rev};
	end

	// ------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_o <= '0;
			start_o <= 1'b0;
			trip_o  <= 1'b0;
			blk_r   <= 1'b0;
		end else begin
			rdata_o <= rd_i ? rdata_nxt : 32'h0;
			blk_r   <= block_i;
			// RULE14 start drives other stages' block inputs
			start_o <= !block_i && ((st_nxt != ST_IDLE) || (force_r && fstart_r));
			// RULE15 block wins over forcing too
			trip_o  <= !block_i && ((st_nxt == ST_TRIP) || (trip_r && st_nxt != ST_IDLE)
				|| (force_r && ftrip_r));
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_late_peak;
		st_r == ST_RUN && op_done && !peak_ok && qual && !block_i
			&& 5'(pk_cnt_r + 5'h1) == as.peaks && !int_done;
	endsequence
	sequence s_trip_next;
		!block_i ##1 !block_i && trip_o;
	endsequence

	a_trip_all_met: assert property ($rose(trip_r) |-> $past(op_done && peak_ok)) // RULE1
		else $error("trip without all criteria");
	a_late_peak_trip: assert property (s_late_peak |=> s_trip_next) // RULE5
		else $error("late last peak did not trip");
	a_window_release: assert property (st_r == ST_RUN && int_done && !(op_done && peak_ok)
		&& !block_i |=> st_r == ST_HOLD && !trip_r) // RULE6
		else $error("window expiry did not release");
	a_delay_resume: assert property (st_r == ST_HOLD && qual && !block_i
		|=> st_r == ST_RUN && op_cnt_r == $past(op_cnt_r)) // RULE7
		else $error("delay count not resumed");
	a_hold_keeps_start: assert property (st_r == ST_HOLD && !rst_done && !qual && !block_i
		|=> start_o) // RULE8
		else $error("start released before reset delay");
	a_peak_setting: assert property (as.peaks >= 5'(PEAKS_MIN) && as.peaks <= 5'(PEAKS_MAX)
		&& as.tdly >= 16'({11'h0, as.peaks} * PEAK_TICKS)) // RULE12
		else $error("illegal active settings");
	a_block_quiet: assert property (block_i |=> !start_o && !trip_o && st_r == ST_IDLE) // RULE15
		else $error("blocked stage active");
	a_start_count: assert property (s_evt && !wr_ctrl |=> scnt_r == 16'($past(scnt_r) + 16'h1)) // RULE16
		else $error("start counter missed");
	a_force_tmo: assert property (force_r && frc_cnt_r >= FORCE_TICKS && !wr_ctrl
		|=> !force_r) // RULE18
		else $error("force flag did not time out");

endmodule // iefs_stage

// file: src/iefs_pkg.sv
// Constants, register map and carrier types of the intermittent earth fault stage
package iefs_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ          = 250_000_000;
	localparam int TICK_MS         = 10;
	localparam int TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
	localparam int FORCE_TMO_S     = 300;
	localparam logic [15:0] FORCE_TICKS = 16'(FORCE_TMO_S * 1000 / TICK_MS);
	localparam int PEAK_GAP_MS     = 10;
	localparam logic [15:0] PEAK_TICKS  = 16'(PEAK_GAP_MS / TICK_MS);

	// ------------------------------------------------------------
	// Setting limits, in ticks or peaks
	// ------------------------------------------------------------
	localparam int MAX_MS          = 300_000;
	localparam logic [15:0] T_MAX       = 16'(MAX_MS / TICK_MS);
	localparam int TDLY_MIN_MS     = 20;
	localparam logic [15:0] TDLY_MIN    = 16'(TDLY_MIN_MS / TICK_MS);
	localparam int INT_MIN_MS      = 10;
	localparam logic [15:0] INT_MIN     = 16'(INT_MIN_MS / TICK_MS);
	localparam int RST_MIN_MS      = 60;
	localparam logic [15:0] RST_MIN     = 16'(RST_MIN_MS / TICK_MS);
	localparam logic [31:0] PEAKS_MIN   = 32'h0000_0001;
	localparam logic [31:0] PEAKS_MAX   = 32'h0000_0014;
	localparam logic [15:0] IO_PICKUP   = 16'h0100;
	localparam logic [7:0]  PCT_FULL    = 8'h64;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W          = 10;
	localparam logic [9:0] A_CTRL       = 10'h000;
	localparam logic [9:0] A_STAT       = 10'h004;
	localparam logic [9:0] A_SCNT       = 10'h008;
	localparam logic [9:0] A_TCNT       = 10'h00c;
	localparam logic [2:0] GRP_PAGE     = 3'h1;
	localparam logic [1:0] REC_PAGE     = 2'h1;
	localparam logic [2:0] F_TDLY       = 3'h0;
	localparam logic [2:0] F_PEAKS      = 3'h1;
	localparam logic [2:0] F_INT        = 3'h2;
	localparam logic [2:0] F_RST        = 3'h3;
	localparam logic [2:0] F_UOPK       = 3'h4;
	localparam logic [2:0] F_DIR        = 3'h5;
	localparam logic [2:0] R_STAMP      = 3'h0;
	localparam logic [2:0] R_MAXIO      = 3'h1;
	localparam logic [2:0] R_MAXUO      = 3'h2;
	localparam logic [2:0] R_ELAPSED_DELAY_PCT       = 3'h3;
	localparam logic [2:0] R_GRP        = 3'h4;
	localparam logic [2:0] R_FWD        = 3'h5;
	localparam logic [2:0] R_REV        = 3'h6;

	// Control bits
	localparam int C_FORCE  = 0;
	localparam int C_GSRC   = 1;
	localparam int C_GRP_LO = 2;
	localparam int C_CLRS   = 4;
	localparam int C_CLRT   = 5;
	localparam int C_CLRE   = 6;
	localparam int C_FSTART = 8;
	localparam int C_FTRIP  = 9;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] tdly;
		logic [4:0]  peaks;
		logic [15:0] intrmt;
		logic [15:0] rst;
		logic [15:0] uo_pk;
		logic        dir_rev;
	} iefs_set_t;

	typedef struct packed {
		logic [31:0] stamp;
		logic [15:0] max_io;
		logic [15:0] max_uo;
		logic [7:0]  elapsed_delay_pct;
		logic [1:0]  grp;
		logic [7:0]  fwd;
		logic [7:0]  rev;
	} iefs_rec_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_TRIP = 2'b11,
		ST_HOLD = 2'b10
	} iefs_state_t;

	localparam iefs_set_t SET_RST = '{tdly: 16'h0010, peaks: 5'h02, intrmt: 16'h0014,
		rst: 16'h0006, uo_pk: 16'h0800, dir_rev: 1'b0};
	localparam iefs_rec_t REC_RST = '0;

endpackage

// file: tb/iefs_front.sv
// Front-end model: residual current samples with peak, voltage and direction
`timescale 1ns/1ps
module iefs_front
	import iefs_pkg::*;
#(
	parameter logic [15:0] FUND_PK = 16'h0200
) (
	// Clock and command
	input  wire logic               clk_i,
	input  wire logic               fire_i,
	input  wire logic signed [15:0] mag_i,
	input  wire logic [15:0]        uo_set_i,
	input  wire logic               fwd_i,
	// Sample stream
	output logic                    smp_vld_o,
	output logic signed [15:0]      io_smp_o,
	output logic [15:0]             io_fund_pk_o,
	output logic [15:0]             uo_o,
	output logic                    dir_fwd_o
);
	initial begin
		{smp_vld_o, io_smp_o, uo_o, dir_fwd_o} = '0;
	end
	// sample qualifiers
	// Between samples the fields toggle, so a stale value is never taken as data
	always @(posedge clk_i) begin
		smp_vld_o <= fire_i;
		io_smp_o  <= fire_i ? mag_i : ~io_smp_o;
		uo_o      <= fire_i ? uo_set_i : ~uo_o;
		dir_fwd_o <= fire_i ? fwd_i : ~dir_fwd_o;
	end
	assign io_fund_pk_o = FUND_PK;
endmodule // iefs_front

// file: tb/tb_top.sv
// Self-checking bench of the intermittent earth fault stage
`timescale 1ns/1ps
module tb_top
	import iefs_pkg::*;
;
	// Short tick keeps every episode timer count within a few hundred cycles
	localparam int TK = 4;
	localparam logic [9:0] BAD_A [5] = '{10'h084, 10'h084, 10'h080, 10'h088, 10'h08c};
	localparam logic [31:0] BAD_D [5] = '{32'h14, 32'h15, 32'h1, 32'h0, 32'h5};
	localparam logic [31:0] OLD_D [5] = '{32'h2, 32'h2, 32'h10, 32'h14, 32'h6};
	logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, block_i = 1'b0, fire = 1'b0, fwd = 1'b1;
	logic smp_vld, dir_fwd, start_o, trip_o;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [31:0] wdata_i = '0, rdata_o, rnd = 32'he9f2;
	logic signed [15:0] mag = '0, io_smp;
	logic [15:0] uo_set = '0, fund, uo;
	logic [1:0] grp_ext_i = 2'h0;
	int err_count = 0, checked = 0;

	always #2 clk_i = ~clk_i;

	iefs_stage #(.TICK_CYCLES(TK)) uut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .smp_vld_i(smp_vld), .io_smp_i(io_smp), .io_fund_pk_i(fund),
		.uo_i(uo), .dir_fwd_i(dir_fwd), .rtc_i(rnd), .block_i(block_i), .grp_ext_i(grp_ext_i), .start_o(start_o),
		.trip_o(trip_o));
	iefs_front u_front (.clk_i(clk_i), .fire_i(fire), .mag_i(mag), .uo_set_i(uo_set), .fwd_i(fwd),
		.smp_vld_o(smp_vld), .io_smp_o(io_smp), .io_fund_pk_o(fund), .uo_o(uo), .dir_fwd_o(dir_fwd));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask
	task automatic cfg(input logic [31:0] t, input logic [31:0] p, input logic [31:0] w, input logic [31:0] r);
		// Open the delay first so any legal peak count fits, then narrow it
		wr(10'h080, 32'h7530);
		wr(10'h084, p);
		wr(10'h080, t);
		wr(10'h088, w);
		wr(10'h08c, r);
	endtask
	task automatic peak(input logic dir, input logic [15:0] m, input logic [15:0] u);
		@(posedge clk_i);
		fire <= 1'b1;
		fwd <= dir;
		mag <= rnd[0] ? -m : m;
		uo_set <= u;
		rnd <= lfsr(rnd);
		@(posedge clk_i);
		fire <= 1'b0;
	endtask
	task automatic qp;
		peak(1'b1, 16'h0201 + {3'h0, rnd[13:1]}, 16'h0900 + {8'h0, rnd[8:1]});
	endtask
	task automatic wait_lo;
		int n;
		n = 0;
		while (start_o !== 1'b0 && n < 600) begin
			cyc(1);
			n++;
		end
		chk(32'(n < 600), 32'h1);
	endtask

	initial begin
		cyc(20000);
		err_count++;
		end_of_test();
	end

	initial begin
		cyc(16);
		srst_i <= 1'b0;
		// ------------------------------------------------------------
		// Registers, refused settings, groups
		// ------------------------------------------------------------
		rd(A_STAT, 32'h0);
		rd(10'h3fc, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(BAD_A[i], BAD_D[i]);
			rd(BAD_A[i], OLD_D[i]);
		end
		rd(A_STAT, 32'h80);
		wr(A_CTRL, 32'h40);
		rd(A_STAT, 32'h0);
		cfg(32'h7530, 32'h14, 32'h7530, 32'h7530);
		rd(10'h084, 32'h14);
		rd(10'h080, 32'h7530);
		wr(A_CTRL, 32'h0c);
		rd(A_STAT, 32'h30);
		grp_ext_i <= 2'h2;
		wr(A_CTRL, 32'h02);
		rd(A_STAT, 32'h20);
		wr(A_CTRL, 32'h0);
		// ------------------------------------------------------------
		// Episodes
		// ------------------------------------------------------------
		cfg(8, 2, 20, 6);
		qp();
		cyc(2);
		chk(start_o, 1);
		qp();
		cyc(16);
		chk(trip_o, 0);
		cyc(30);
		chk(trip_o, 1);
		wait_lo();
		rd(A_SCNT, 32'h1);
		rd(A_TCNT, 32'h1);
		rd(10'h10c, 32'h64);
		rd(10'h114, 32'h2);
		rd(10'h118, 32'h0);
		rd(10'h110, 32'h0);
		wr(A_CTRL, 32'h30);
		rd(A_TCNT, 32'h0);
		wr(A_CTRL, 32'h0);
		cfg(4, 3, 20, 6);
		qp();
		qp();
		cyc(40);
		chk(trip_o, 0);
		qp();
		cyc(4);
		chk(trip_o, 1);
		wait_lo();
		cfg(30, 1, 2, 6);
		qp();
		cyc(16);
		chk(start_o, 1);
		cyc(64);
		chk({start_o, trip_o}, 0);
		rd(10'h14c, 32'h6);
		// Two short windows: the delay only completes if it resumes
		cfg(4, 1, 2, 6);
		qp();
		cyc(12);
		qp();
		cyc(12);
		chk(trip_o, 1);
		wait_lo();
		peak(1'b1, 16'h0180, 16'h0900);
		cyc(3);
		chk(start_o, 0);
		peak(1'b1, 16'h4000, 16'h0100);
		cyc(3);
		chk(start_o, 0);
		peak(1'b0, 16'h4000, 16'h0900);
		cyc(3);
		chk(start_o, 0);
		wr(10'h094, 32'h1);
		peak(1'b0, 16'h4000, 16'h0900);
		cyc(3);
		chk(start_o, 1);
		wait_lo();
		wr(10'h094, 32'h0);
		block_i <= 1'b1;
		qp();
		cyc(3);
		chk(start_o, 0);
		rd(A_STAT, 32'h1);
		block_i <= 1'b0;
		wr(A_CTRL, 32'h301);
		cyc(3);
		chk({start_o, trip_o}, 32'h3);
		wr(A_CTRL, 32'h300);
		cyc(3);
		chk({start_o, trip_o}, 0);
		end_of_test();
	end
endmodule // tb_top
